// ===== src/bor_pkg.sv
// What this block does
// - Code 5A enables monitor, 1.7V threshold
// - Code A5 disables monitor, ignores low supply
// - Illegal code: delayed reset, restore control
// - Illegal-code reset sets flag bit 1
// - Brownout only after low exceeds filter
// - Brownout reset sets flag bit 2
// - Brownout reset keeps control register value
// - Monitor active in FAST and SLOW
// - Monitor off in SLEEP and IDLE
// - Control register powers up as 5A
// - Flag bits 7 to 4 read zero
// - Flags set by hardware; software writes set or clear them
// - Watchdog reset running: expiry set, powerdown kept
// - Watchdog reset asleep: only PC, SP cleared
// - Watchdog reset asleep: both flags set
// - POR clears both; pin/brownout keep them
// - POR initialises core, ports, timers, watchdog
// - Illegal pin code: delayed reset, flag bit 3
package bor_pkg;
    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] OFS_MON_CTRL = 8'h00;
    localparam logic [7:0] OFS_FLAGS = 8'h04;
    localparam logic [7:0] OFS_PIN_CODE = 8'h08;
    localparam logic [7:0] OFS_CORE_STAT = 8'h0C;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
    // ****************************************************************
    // Codes and reset values
    // ****************************************************************
    localparam logic [7:0] MON_CODE_ON = 8'h5A;
    localparam logic [7:0] MON_CODE_OFF = 8'hA5;
    localparam logic [7:0] MON_CTRL_POR = 8'h5A;
    localparam logic [7:0] PIN_CODE_GPIO = 8'h55;
    localparam logic [7:0] PIN_CODE_RES = 8'hAA;
    localparam logic [7:0] PIN_CODE_POR = 8'hAA;
    localparam logic [3:0] FLAGS_POR = 4'h0;
    // Flag bits
    localparam int FLG_WDT_CODE = 0;
    localparam int FLG_MON_FAULT = 1;
    localparam int FLG_BROWNOUT = 2;
    localparam int FLG_PIN_FAULT = 3;
    // Core status bits
    localparam int CST_PDF = 0;
    localparam int CST_TO = 1;
    // Interrupt event bits
    localparam int EV_BROWNOUT = 0;
    localparam int EV_MON_FAULT = 1;
    localparam int EV_PIN_FAULT = 2;
    localparam int EV_WDT = 3;
    localparam int EV_N = 4;
    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned BO_FILTER_NS = 120000;
    localparam int unsigned CODE_FAULT_NS = 50000;
    localparam int unsigned BO_FILTER_CYC =
        (BO_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CODE_FAULT_CYC =
        (CODE_FAULT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RESET_PULSE_CYC = 16;
    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {MODE_FAST, MODE_SLOW, MODE_IDLE, MODE_SLEEP}
        bor_mode_e;
    typedef enum logic {ST_RUN, ST_RESET} bor_state_e;
    typedef struct packed {
        logic pc_clear;
        logic irq_disable;
        logic timers_off;
        logic io_inputs;
        logic sp_top;
        logic wdt_clear;
    } bor_init_s;
endpackage : bor_pkg

// ===== src/bor_ctrl.sv
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps
module bor_ctrl #(
    parameter int unsigned FILTER_CYC = bor_pkg::BO_FILTER_CYC,
    parameter int unsigned FAULT_CYC = bor_pkg::CODE_FAULT_CYC,
    parameter int unsigned PULSE_CYC = bor_pkg::RESET_PULSE_CYC,
    parameter int unsigned CNT_W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic low_supply,
    input wire logic reset_pin_n,
    input wire logic wdt_expiry,
    input wire logic wdt_code_fault,
    input wire bor_pkg::bor_mode_e cpu_mode,
    output logic mcu_reset,
    output logic warm_reset,
    output bor_pkg::bor_init_s init_ctrl,
    output logic monitor_on,
    output logic pin_is_reset,
    output logic irq
);
    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    if (FILTER_CYC < 1 || FILTER_CYC >= (1 << CNT_W) ||
        FAULT_CYC < 1 || FAULT_CYC >= (1 << CNT_W) ||
        PULSE_CYC < 1 || PULSE_CYC >= (1 << CNT_W))
    begin : g_bad_param
        $error("bor_ctrl: count does not fit counter");
    end

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    // Second and third stage must agree before a change is believed
    logic [2:0] lsup_sync_r, lsup_sync_nxt;
    logic [2:0] pin_sync_r, pin_sync_nxt;
    always_comb
    begin
        lsup_sync_nxt = {lsup_sync_r[1:0], low_supply};
        pin_sync_nxt = {pin_sync_r[1:0], reset_pin_n};
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lsup_sync_r <= 3'h0;
            pin_sync_r <= 3'h7;
        end
        else
        begin
            lsup_sync_r <= lsup_sync_nxt;
            pin_sync_r <= pin_sync_nxt;
        end
    end

    // ****************************************************************
    // Main state
    // ****************************************************************
    bor_pkg::bor_state_e st_r, st_nxt;
    logic [CNT_W-1:0] pulse_cnt_r, pulse_cnt_nxt;
    logic [CNT_W-1:0] bo_cnt_r, bo_cnt_nxt;
    logic [CNT_W-1:0] mf_cnt_r, mf_cnt_nxt;
    logic [CNT_W-1:0] pf_cnt_r, pf_cnt_nxt;
    logic [7:0] mon_ctrl_r, mon_ctrl_nxt;
    logic [7:0] pin_code_r, pin_code_nxt;
    logic [3:0] flags_r, flags_nxt;
    logic to_r, to_nxt, pdf_r, pdf_nxt;
    logic [bor_pkg::EV_N-1:0] ev_stat_r, ev_stat_nxt;
    logic [bor_pkg::EV_N-1:0] ev_mask_r, ev_mask_nxt;
    logic lsup_lvl_r, lsup_lvl_nxt, pin_lvl_r, pin_lvl_nxt;
    logic por_r, por_nxt;
    logic mcu_reset_r, mcu_reset_nxt, warm_reset_r, warm_reset_nxt;
    bor_pkg::bor_init_s init_r, init_nxt;
    logic monitor_on_r, monitor_on_nxt;
    logic pin_is_reset_r, pin_is_reset_nxt;
    logic irq_r, irq_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;

    logic running, awake, mon_active, bo_cond, mf_bad, pf_bad, pin_fall;
    logic fire_bo, fire_mf, fire_pf, fire_pin, fire_wdt, wdt_asleep;
    logic wr, rd_setup, hit;
    logic [bor_pkg::EV_N-1:0] ev_set;

    always_comb
    begin
        running = (st_r == bor_pkg::ST_RUN);
        awake = (cpu_mode == bor_pkg::MODE_FAST) ||
                (cpu_mode == bor_pkg::MODE_SLOW);
        mon_active = awake && (mon_ctrl_r == bor_pkg::MON_CODE_ON);
        bo_cond = mon_active && lsup_lvl_r;
        // Whole byte compared each cycle so noise on any bit is seen
        mf_bad = (mon_ctrl_r != bor_pkg::MON_CODE_ON) &&
                 (mon_ctrl_r != bor_pkg::MON_CODE_OFF);
        pf_bad = (pin_code_r != bor_pkg::PIN_CODE_GPIO) &&
                 (pin_code_r != bor_pkg::PIN_CODE_RES);
        pin_fall = pin_lvl_r && (pin_sync_r[2:1] == 2'b00) &&
                   (pin_code_r == bor_pkg::PIN_CODE_RES);
        // Held one cycle past the filter count: strictly longer
        fire_bo = running && bo_cond && (bo_cnt_r == CNT_W'(FILTER_CYC));
        fire_mf = running && !fire_bo && mf_bad &&
                  (mf_cnt_r == CNT_W'(FAULT_CYC - 1));
        fire_pf = running && !fire_bo && !fire_mf && pf_bad &&
                  (pf_cnt_r == CNT_W'(FAULT_CYC - 1));
        fire_pin = running && !fire_bo && !fire_mf && !fire_pf && pin_fall;
        fire_wdt = running && !fire_bo && !fire_mf && !fire_pf &&
                   !fire_pin && wdt_expiry;
        wdt_asleep = fire_wdt && !awake;
        wr = psel && penable && pready_r && pwrite;
        rd_setup = psel && !penable;
        hit = (paddr == bor_pkg::OFS_MON_CTRL) ||
              (paddr == bor_pkg::OFS_FLAGS) ||
              (paddr == bor_pkg::OFS_PIN_CODE) ||
              (paddr == bor_pkg::OFS_CORE_STAT) ||
              (paddr == bor_pkg::OFS_IRQ_STAT) ||
              (paddr == bor_pkg::OFS_IRQ_MASK);
        ev_set = '0;
        ev_set[bor_pkg::EV_BROWNOUT] = fire_bo;
        ev_set[bor_pkg::EV_MON_FAULT] = fire_mf;
        ev_set[bor_pkg::EV_PIN_FAULT] = fire_pf;
        ev_set[bor_pkg::EV_WDT] = fire_wdt;
    end

    always_comb
    begin
        st_nxt = st_r;
        pulse_cnt_nxt = pulse_cnt_r;
        mon_ctrl_nxt = mon_ctrl_r;
        pin_code_nxt = pin_code_r;
        flags_nxt = flags_r;
        to_nxt = to_r;
        pdf_nxt = pdf_r;
        ev_stat_nxt = ev_stat_r;
        ev_mask_nxt = ev_mask_r;
        por_nxt = por_r;
        init_nxt = init_r;
        lsup_lvl_nxt = lsup_lvl_r;
        pin_lvl_nxt = pin_lvl_r;
        if (lsup_sync_r[2] == lsup_sync_r[1])
            lsup_lvl_nxt = lsup_sync_r[2];
        if (pin_sync_r[2] == pin_sync_r[1])
            pin_lvl_nxt = pin_sync_r[2];
        // Filter and fault counters, held clear while a reset is out
        bo_cnt_nxt = (running && bo_cond && !fire_bo) ?
                     bo_cnt_r + CNT_W'(1) : '0;
        mf_cnt_nxt = (running && mf_bad && !fire_mf) ?
                     mf_cnt_r + CNT_W'(1) : '0;
        pf_cnt_nxt = (running && pf_bad && !fire_pf) ?
                     pf_cnt_r + CNT_W'(1) : '0;
        // Software side; hardware sets below win over these
        if (wr)
        begin
            unique case (paddr)
                bor_pkg::OFS_MON_CTRL: mon_ctrl_nxt = pwdata[7:0];
                bor_pkg::OFS_PIN_CODE: pin_code_nxt = pwdata[7:0];
                bor_pkg::OFS_FLAGS: flags_nxt = pwdata[3:0];
                bor_pkg::OFS_IRQ_STAT:
                    ev_stat_nxt = ev_stat_r & ~pwdata[bor_pkg::EV_N-1:0];
                bor_pkg::OFS_IRQ_MASK:
                    ev_mask_nxt = pwdata[bor_pkg::EV_N-1:0];
                default: ;
            endcase
        end
        ev_stat_nxt = ev_stat_nxt | ev_set;
        if (wdt_code_fault)
            flags_nxt[bor_pkg::FLG_WDT_CODE] = 1'b1;
        if (running && !awake)
            pdf_nxt = 1'b1;
        // Reset sources: each applies its own register effects once
        if (fire_bo)
        begin
            flags_nxt[bor_pkg::FLG_BROWNOUT] = 1'b1;
            pin_code_nxt = bor_pkg::PIN_CODE_POR;
        end
        if (fire_mf)
        begin
            flags_nxt[bor_pkg::FLG_MON_FAULT] = 1'b1;
            mon_ctrl_nxt = bor_pkg::MON_CTRL_POR;
            pin_code_nxt = bor_pkg::PIN_CODE_POR;
        end
        if (fire_pf)
        begin
            flags_nxt[bor_pkg::FLG_PIN_FAULT] = 1'b1;
            mon_ctrl_nxt = bor_pkg::MON_CTRL_POR;
            pin_code_nxt = bor_pkg::PIN_CODE_POR;
        end
        if (fire_pin)
        begin
            mon_ctrl_nxt = bor_pkg::MON_CTRL_POR;
            pin_code_nxt = bor_pkg::PIN_CODE_POR;
        end
        if (fire_wdt)
        begin
            to_nxt = 1'b1;
            if (wdt_asleep)
                pdf_nxt = 1'b1;
            else
            begin
                mon_ctrl_nxt = bor_pkg::MON_CTRL_POR;
                pin_code_nxt = bor_pkg::PIN_CODE_POR;
            end
        end
        unique case (st_r)
            bor_pkg::ST_RUN:
            begin
                if (fire_bo || fire_mf || fire_pf || fire_pin || fire_wdt)
                begin
                    st_nxt = bor_pkg::ST_RESET;
                    pulse_cnt_nxt = CNT_W'(PULSE_CYC - 1);
                end
            end
            bor_pkg::ST_RESET:
            begin
                if (pulse_cnt_r == '0)
                begin
                    st_nxt = bor_pkg::ST_RUN;
                    por_nxt = 1'b0;
                    init_nxt = '0;
                end
                else
                    pulse_cnt_nxt = pulse_cnt_r - CNT_W'(1);
            end
        endcase
    end

    // ****************************************************************
    // Output stage
    // ****************************************************************
    always_comb
    begin
        monitor_on_nxt = running && mon_active;
        pin_is_reset_nxt = (pin_code_r == bor_pkg::PIN_CODE_RES);
        // Asleep watchdog only rewinds PC and SP, no full reset
        mcu_reset_nxt = (st_nxt == bor_pkg::ST_RESET) &&
                        !(wdt_asleep || (!running && warm_reset_r));
        warm_reset_nxt = (st_nxt == bor_pkg::ST_RESET) &&
                         (wdt_asleep || (!running && warm_reset_r));
        irq_nxt = |(ev_stat_nxt & ev_mask_nxt);
        pready_nxt = rd_setup;
        pslverr_nxt = rd_setup && !hit;
        prdata_nxt = prdata_r;
        if (rd_setup)
        begin
            prdata_nxt = 32'h0;
            unique case (paddr)
                bor_pkg::OFS_MON_CTRL: prdata_nxt[7:0] = mon_ctrl_r;
                bor_pkg::OFS_FLAGS: prdata_nxt[3:0] = flags_r;
                bor_pkg::OFS_PIN_CODE: prdata_nxt[7:0] = pin_code_r;
                bor_pkg::OFS_CORE_STAT:
                begin
                    prdata_nxt[bor_pkg::CST_PDF] = pdf_r;
                    prdata_nxt[bor_pkg::CST_TO] = to_r;
                end
                bor_pkg::OFS_IRQ_STAT:
                    prdata_nxt[bor_pkg::EV_N-1:0] = ev_stat_r;
                bor_pkg::OFS_IRQ_MASK:
                    prdata_nxt[bor_pkg::EV_N-1:0] = ev_mask_r;
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            // Power-on: reset pulse with full core initialisation
            st_r <= bor_pkg::ST_RESET;
            pulse_cnt_r <= CNT_W'(PULSE_CYC - 1);
            bo_cnt_r <= '0;
            mf_cnt_r <= '0;
            pf_cnt_r <= '0;
            mon_ctrl_r <= bor_pkg::MON_CTRL_POR;
            pin_code_r <= bor_pkg::PIN_CODE_POR;
            flags_r <= bor_pkg::FLAGS_POR;
            to_r <= 1'b0;
            pdf_r <= 1'b0;
            ev_stat_r <= '0;
            ev_mask_r <= '0;
            lsup_lvl_r <= 1'b0;
            pin_lvl_r <= 1'b1;
            por_r <= 1'b1;
            init_r <= '1;
            mcu_reset_r <= 1'b1;
            warm_reset_r <= 1'b0;
            monitor_on_r <= 1'b0;
            pin_is_reset_r <= 1'b1;
            irq_r <= 1'b0;
            prdata_r <= 32'h0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            pulse_cnt_r <= pulse_cnt_nxt;
            bo_cnt_r <= bo_cnt_nxt;
            mf_cnt_r <= mf_cnt_nxt;
            pf_cnt_r <= pf_cnt_nxt;
            mon_ctrl_r <= mon_ctrl_nxt;
            pin_code_r <= pin_code_nxt;
            flags_r <= flags_nxt;
            to_r <= to_nxt;
            pdf_r <= pdf_nxt;
            ev_stat_r <= ev_stat_nxt;
            ev_mask_r <= ev_mask_nxt;
            lsup_lvl_r <= lsup_lvl_nxt;
            pin_lvl_r <= pin_lvl_nxt;
            por_r <= por_nxt;
            init_r <= init_nxt;
            mcu_reset_r <= mcu_reset_nxt;
            warm_reset_r <= warm_reset_nxt;
            monitor_on_r <= monitor_on_nxt;
            pin_is_reset_r <= pin_is_reset_nxt;
            irq_r <= irq_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    always_comb
    begin
        prdata = prdata_r;
        pready = pready_r;
        pslverr = pslverr_r;
        mcu_reset = mcu_reset_r;
        warm_reset = warm_reset_r;
        init_ctrl = init_r;
        monitor_on = monitor_on_r;
        pin_is_reset = pin_is_reset_r;
        irq = irq_r;
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_mon_on;
        running && awake && mon_ctrl_r == bor_pkg::MON_CODE_ON |=> monitor_on_r;
    endproperty
    a_mon_on: assert property (p_mon_on) else $error("monitor not on");
    property p_mon_off;
        mon_ctrl_r == bor_pkg::MON_CODE_OFF |=> !monitor_on_r && !fire_bo;
    endproperty
    a_mon_off: assert property (p_mon_off) else $error("monitor not off");
    property p_fault_restore;
        fire_mf |=> mon_ctrl_r == bor_pkg::MON_CTRL_POR && mcu_reset_r
            && flags_r[bor_pkg::FLG_MON_FAULT];
    endproperty
    a_fault_restore: assert property (p_fault_restore) else $error("fault");
    property p_fault_delay;
        running && mf_bad && mf_cnt_r == '0 |-> !fire_mf [*2];
    endproperty
    a_fault_delay: assert property (p_fault_delay) else $error("early");
    property p_bo_filter;
        fire_bo |-> bo_cnt_r == CNT_W'(FILTER_CYC) && $past(bo_cond);
    endproperty
    a_bo_filter: assert property (p_bo_filter) else $error("filter");
    property p_bo_effect;
        fire_bo |=> mcu_reset_r && flags_r[bor_pkg::FLG_BROWNOUT]
            && mon_ctrl_r == $past(mon_ctrl_r);
    endproperty
    a_bo_effect: assert property (p_bo_effect) else $error("brownout");
    property p_sleep_off;
        !awake |=> !monitor_on_r;
    endproperty
    a_sleep_off: assert property (p_sleep_off) else $error("asleep on");
    property p_flags_hi;
        rd_setup && paddr == bor_pkg::OFS_FLAGS |=> prdata_r[31:4] == '0;
    endproperty
    a_flags_hi: assert property (p_flags_hi) else $error("flag bits");
    property p_sticky;
        flags_r[bor_pkg::FLG_BROWNOUT] && !wr |=> flags_r[bor_pkg::FLG_BROWNOUT];
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag lost");
    property p_wdt_run;
        fire_wdt && awake |=> to_r && pdf_r == $past(pdf_r) && mcu_reset_r;
    endproperty
    a_wdt_run: assert property (p_wdt_run) else $error("wdt run");
    property p_wdt_sleep;
        wdt_asleep |=> warm_reset_r && !mcu_reset_r && to_r && pdf_r;
    endproperty
    a_wdt_sleep: assert property (p_wdt_sleep) else $error("wdt sleep");
    property p_pin_keep;
        fire_pin |=> to_r == $past(to_r) && pdf_r == $past(pdf_r);
    endproperty
    a_pin_keep: assert property (p_pin_keep) else $error("pin flags");
    property p_por_init;
        por_r |-> init_r == '1 && mcu_reset_r;
    endproperty
    a_por_init: assert property (p_por_init) else $error("por init");
    property p_pin_fault;
        fire_pf |=> flags_r[bor_pkg::FLG_PIN_FAULT] && mcu_reset_r;
    endproperty
    a_pin_fault: assert property (p_pin_fault) else $error("pin fault");

    c_brownout: cover property (fire_bo);
    c_mon_fault: cover property (fire_mf);
    c_wdt_sleep: cover property (wdt_asleep);
    c_irq: cover property (irq_r);
endmodule : bor_ctrl

// ===== testbench/bor_far_model.sv
`timescale 1ns/1ps
// ********
// Supply comparator model
// ********
module bor_far_model (
    input wire logic pclk,
    input wire logic dip_go,
    input wire logic [7:0] dip_len,
    output logic low_supply
);
    logic [7:0] left_r = 8'h00;
    // Whole dip held as one level, like a slow supply sag
    always_ff @(posedge pclk)
    begin
        if (dip_go)
            left_r <= dip_len;
        else if (left_r != 8'h00)
            left_r <= left_r - 8'h01;
    end
    assign low_supply = (left_r != 8'h00);
endmodule : bor_far_model

// ===== testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        logic w;
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] x;
    } bor_row_s;
    // ********
    // Signals
    // ********
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic low_supply;
    logic reset_pin_n = 1'b1;
    logic wdt_expiry = 1'b0;
    logic wdt_code_fault = 1'b0;
    bor_pkg::bor_mode_e cpu_mode = bor_pkg::MODE_FAST;
    logic mcu_reset;
    logic warm_reset;
    bor_pkg::bor_init_s init_ctrl;
    logic monitor_on;
    logic pin_is_reset;
    logic irq;
    logic dip_go = 1'b0;
    logic [7:0] dip_len = 8'h00;
    int n_errors = 0;
    int n_checks = 0;
    logic [31:0] q;
    logic e;
    bor_row_s rows [12] = '{
        '{1'b0, 8'h00, 32'h0, 32'h5A},
        '{1'b0, 8'h04, 32'h0, 32'h0},
        '{1'b0, 8'h08, 32'h0, 32'hAA},
        '{1'b0, 8'h0C, 32'h0, 32'h0},
        '{1'b0, 8'h14, 32'h0, 32'h0},
        '{1'b1, 8'h04, 32'hFF, 32'h0},
        '{1'b0, 8'h04, 32'h0, 32'h0F},
        '{1'b1, 8'h04, 32'h0, 32'h0},
        '{1'b0, 8'h10, 32'h0, 32'h0},
        '{1'b1, 8'h08, 32'h55, 32'h0},
        '{1'b0, 8'h08, 32'h0, 32'h55},
        '{1'b1, 8'h08, 32'hAA, 32'h0}
    };
    // Short counts keep the run brief
    bor_ctrl #(.FILTER_CYC(4), .FAULT_CYC(4), .PULSE_CYC(4)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .low_supply(low_supply),
        .reset_pin_n(reset_pin_n), .wdt_expiry(wdt_expiry),
        .wdt_code_fault(wdt_code_fault), .cpu_mode(cpu_mode),
        .mcu_reset(mcu_reset), .warm_reset(warm_reset),
        .init_ctrl(init_ctrl), .monitor_on(monitor_on),
        .pin_is_reset(pin_is_reset), .irq(irq)
    );
    bor_far_model i_far (
        .pclk(pclk), .dip_go(dip_go), .dip_len(dip_len),
        .low_supply(low_supply)
    );
    // ********
    // Tasks
    // ********
    task automatic chk(input string nm, input logic [31:0] x,
        input logic [31:0] g);
        n_checks++;
        if (g !== x)
        begin
            n_errors++;
            $display("[FAIL] %s exp %h got %h", nm, x, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Answer taken at the edge where pready is sampled high
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] x,
        input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, x, q);
    endtask : rd
    task automatic settle();
        repeat (2) @(negedge pclk);
    endtask : settle
    // Fixed window: fire plus pulse fit well inside it
    task automatic watch(input logic warm, input logic x, input string nm);
        logic hit;
        logic bad;
        hit = 1'b0;
        bad = 1'b0;
        repeat (40)
        begin
            @(negedge pclk);
            if ((warm ? warm_reset : mcu_reset) === 1'b1)
                hit = 1'b1;
            if ((warm ? mcu_reset : warm_reset) === 1'b1)
                bad = 1'b1;
        end
        chk(nm, 32'(x), 32'(hit));
        chk(nm, 32'h0, 32'(bad));
    endtask : watch
    task automatic dip(input logic [7:0] l);
        @(posedge pclk);
        dip_len <= l;
        dip_go <= 1'b1;
        @(posedge pclk);
        dip_go <= 1'b0;
    endtask : dip
    task automatic wdt_kick();
        @(posedge pclk);
        wdt_expiry <= 1'b1;
        @(posedge pclk);
        wdt_expiry <= 1'b0;
    endtask : wdt_kick
    task automatic por();
        @(posedge pclk);
        presetn <= 1'b0;
        @(negedge pclk);
        chk("init_ctrl", 32'h3F, 32'(init_ctrl));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (10) @(posedge pclk);
        chk("init_ctrl run", 32'h0, 32'(init_ctrl));
    endtask : por
    task automatic close_out();
        if (n_errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out
    // ********
    // Sequence
    // ********
    initial
    begin
        forever #50 pclk = ~pclk;
    end
    initial
    begin
        #1_000_000;
        n_errors++;
        close_out();
    end
    initial
    begin
        por();
        chk("monitor_on", 32'h1, 32'(monitor_on));
        chk("pin_is_reset", 32'h1, 32'(pin_is_reset));
        foreach (rows[i])
        begin
            if (rows[i].w)
                apb(1'b1, rows[i].a, rows[i].d);
            else
                rd(rows[i].a, rows[i].x, $sformatf("row %0d", i));
        end
        rd(8'h20, 32'h0, "unmapped");
        chk("pslverr", 32'h1, 32'(e));
        apb(1'b1, 8'h00, 32'hA5);
        settle();
        chk("monitor_on", 32'h0, 32'(monitor_on));
        dip(8'h0C);
        watch(1'b0, 1'b0, "off dip");
        apb(1'b1, 8'h00, 32'h5A);
        dip(8'h03);
        watch(1'b0, 1'b0, "short dip");
        dip(8'h0C);
        watch(1'b0, 1'b1, "brownout");
        rd(8'h04, 32'h4, "flags bo");
        rd(8'h00, 32'h5A, "code bo");
        rd(8'h10, 32'h1, "event bo");
        apb(1'b1, 8'h14, 32'h1);
        settle();
        chk("irq on", 32'h1, 32'(irq));
        apb(1'b1, 8'h14, 32'h0);
        settle();
        chk("irq masked", 32'h0, 32'(irq));
        apb(1'b1, 8'h14, 32'h1);
        apb(1'b1, 8'h10, 32'h1);
        settle();
        chk("irq cleared", 32'h0, 32'(irq));
        apb(1'b1, 8'h00, 32'h5B);
        watch(1'b0, 1'b1, "code fault");
        rd(8'h00, 32'h5A, "code back");
        rd(8'h04, 32'h6, "flags cf");
        apb(1'b1, 8'h08, 32'h12);
        watch(1'b0, 1'b1, "pin fault");
        rd(8'h04, 32'hE, "flags pf");
        rd(8'h08, 32'hAA, "pin back");
        wdt_kick();
        watch(1'b0, 1'b1, "wdt run");
        rd(8'h0C, 32'h2, "core run");
        @(posedge pclk);
        cpu_mode <= bor_pkg::MODE_SLEEP;
        settle();
        chk("monitor sleep", 32'h0, 32'(monitor_on));
        @(posedge pclk);
        cpu_mode <= bor_pkg::MODE_IDLE;
        wdt_kick();
        watch(1'b1, 1'b1, "wdt sleep");
        rd(8'h0C, 32'h3, "core sleep");
        @(posedge pclk);
        cpu_mode <= bor_pkg::MODE_SLOW;
        wdt_code_fault <= 1'b1;
        @(posedge pclk);
        wdt_code_fault <= 1'b0;
        settle();
        chk("monitor slow", 32'h1, 32'(monitor_on));
        @(posedge pclk);
        reset_pin_n <= 1'b0;
        watch(1'b0, 1'b1, "pin reset");
        @(posedge pclk);
        reset_pin_n <= 1'b1;
        rd(8'h04, 32'hF, "flags pin");
        rd(8'h0C, 32'h3, "core pin");
        por();
        rd(8'h0C, 32'h0, "core por");
        rd(8'h04, 32'h0, "flags por");
        rd(8'h00, 32'h5A, "code por");
        close_out();
    end
endmodule : testbench
